// ===== mbl_top.v
// Mirror block load sequencer: init, block load handshake and pulse control.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "mbl_defines.vh"
module mbl_top #(
  parameter [15:0] DEV_ID  = 16'h5a01, // arbitrary value
  parameter [15:0] VERSION = 16'h0100  // arbitrary value
) (
  input  wire        pclk,                 // system clock, 100 MHz
  input  wire        presetn,              // async reset, active low
  input  wire [7:0]  paddr,                // APB address
  input  wire        psel,                 // APB select
  input  wire        penable,              // APB enable
  input  wire        pwrite,               // APB write
  input  wire [31:0] pwdata,               // APB write data
  output reg  [31:0] prdata,               // APB read data
  output wire        pready,               // APB ready
  output wire        pslverr,              // APB error
  input  wire        array_present,        // array attached pin
  input  wire [1:0]  array_id,             // array type pins
  output reg         config_done,          // configuration complete
  output reg         init_done,            // initialisation complete
  input  wire        cw_valid,             // control word valid
  input  wire [1:0]  cw_chan,              // control word channel
  input  wire [63:0] cw_data,              // control word
  input  wire        s_valid,              // stream valid
  output wire        s_ready,              // stream ready
  input  wire [31:0] s_data,               // stream data
  input  wire        block_load_request,   // end of block pin
  output wire        block_busy_n,         // block loading busy, low
  input  wire [3:0]  mirror_block_select,  // block for pulse
  input  wire [1:0]  pulse_type_select,    // pulse kind
  input  wire        mirror_pulse_go,      // pulse start pin
  output wire        mirror_pulse_running, // pulse in progress
  output wire        arr_valid,            // array data valid
  input  wire        arr_ready,            // array data accept
  output wire [31:0] arr_data,             // array data
  output reg  [7:0]  arr_row,              // array row address
  output reg  [3:0]  arr_block,            // array load block
  output wire        arr_init,             // array setup active
  output reg         mirror_clock_pulse,   // pulse strobe
  output reg  [1:0]  pulse_type_out,       // applied pulse kind
  output reg  [3:0]  pulse_block_out       // applied pulse block
);
  localparam [2:0] ST_DETECT = 3'h0;
  localparam [2:0] ST_CONFIG = 3'h1;
  localparam [2:0] ST_INIT   = 3'h2;
  localparam [2:0] ST_IDLE   = 3'h3;
  localparam [2:0] ST_OPEN   = 3'h4;
  localparam [2:0] ST_LOAD   = 3'h5;
  localparam [1:0] PS_IDLE   = 2'h0;
  localparam [1:0] PS_RUN    = 2'h1;
  localparam [1:0] PS_SETTLE = 2'h2;
  // Counts are worked out as integers, then cut to the counter width on purpose.
  localparam integer PULSE_I  = `MBL_PULSE_CYC;
  localparam integer SETTLE_I = `MBL_SETTLE_CYC;
  localparam integer LOAD_I   = `MBL_LOAD_CYC;
  localparam integer INIT_I   = `MBL_INIT_CYC;
  localparam [9:0] PULSE_CYC  = PULSE_I[9:0];
  localparam [9:0] SETTLE_CYC = SETTLE_I[9:0];
  localparam [9:0] LOAD_CYC   = LOAD_I[9:0];
  localparam [9:0] INIT_CYC   = INIT_I[9:0];

  wire [10:0] pins_s;
  wire        present_s;
  wire [1:0]  id_s;
  wire        req_s;
  wire        go_s;
  wire [3:0]  blk_s;
  wire [1:0]  type_s;
  reg         req_q_r;
  reg         go_q_r;
  wire        req_rise;
  wire        go_rise;

  reg  [2:0]  state_r;
  reg  [1:0]  pstate_r;
  reg  [9:0]  cnt_r;
  reg  [9:0]  pcnt_r;
  reg  [1:0]  cfg_sel_r;
  reg         loaded_r;
  reg         fwd_en_r;
  reg         reinit_r;
  reg  [63:0] cw_last_r;
  reg  [7:0]  blocks_r;
  reg  [7:0]  pulses_r;
  reg  [7:0]  drops_r;

  wire        open_st;
  wire        drain_st;
  wire        flush_st;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire        fifo_out_ready;
  wire [4:0]  fifo_level;
  wire        cw_take;
  wire        cw_drop;
  wire        arr_take;
  wire        go_take;
  wire        apb_wr;
  wire        apb_setup;
  reg  [31:0] rd_val;
  reg         hit;

  // Pin levels reset low, their idle level, so no false edge follows reset.
  mbl_sync #(
    .W (11)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({array_present, array_id, block_load_request, mirror_pulse_go,
                mirror_block_select, pulse_type_select}),
    .q       (pins_s)
  );

  assign present_s = pins_s[10];
  assign id_s      = pins_s[9:8];
  assign req_s     = pins_s[7];
  assign go_s      = pins_s[6];
  assign blk_s     = pins_s[5:2];
  assign type_s    = pins_s[1:0];
  assign req_rise  = req_s & ~req_q_r;
  assign go_rise   = go_s & ~go_q_r;

  assign open_st  = (state_r == ST_OPEN);
  assign drain_st = open_st | (state_r == ST_LOAD);

  // Stream is stalled until a block is open, so data never precedes its word.
  assign s_ready        = fifo_in_ready & open_st;
  assign arr_valid      = fifo_out_valid & drain_st & fwd_en_r;
  // Words left from a cut block are dropped during restart, never forwarded later.
  assign flush_st       = (state_r == ST_DETECT) | (state_r == ST_CONFIG) | arr_init;
  assign fifo_out_ready = (arr_ready & drain_st & fwd_en_r) | flush_st;
  assign arr_take       = arr_valid & arr_ready;

  mbl_fifo #(
    .W  (`MBL_FIFO_W),
    .D  (`MBL_FIFO_D),
    .AW (`MBL_FIFO_AW)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (s_valid & open_st),
    .in_ready  (fifo_in_ready),
    .in_data   (s_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (arr_data),
    .level     (fifo_level)
  );

  // R6: channel filter
  assign cw_drop = cw_valid & (cw_chan != 2'h0);
  // A word arriving outside idle is lost, not held back for later.
  assign cw_take = cw_valid & (cw_chan == 2'h0) & (state_r == ST_IDLE);

  // Edge, not level: a go held through a busy phase never fires late.
  // R12: pulse start gate
  assign go_take = go_rise & (pstate_r == PS_IDLE) & block_busy_n & loaded_r & init_done;

  // R9: busy while loading
  assign block_busy_n = (state_r != ST_LOAD);
  // R13: running during pulse
  assign mirror_pulse_running = (pstate_r == PS_RUN);
  assign arr_init = (state_r == ST_INIT);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ST_DETECT;
      cnt_r       <= 10'h000;
      cfg_sel_r   <= 2'h0;
      init_done   <= 1'b0;
      config_done <= 1'b0;
      loaded_r    <= 1'b0;
      cw_last_r   <= 64'h0000000000000000;
      arr_row     <= 8'h00;
      arr_block   <= 4'h0;
      blocks_r    <= 8'h00;
      drops_r     <= 8'h00;
      req_q_r     <= 1'b0;
    end else begin
      config_done <= 1'b1;
      req_q_r     <= req_s;
      if (cw_drop) begin
        drops_r <= drops_r + 8'h01;
      end
      if (arr_take) begin
        arr_row <= (arr_row == `MBL_BLOCK_ROWS - 8'h01) ? 8'h00 : arr_row + 8'h01;
      end
      case (state_r)
        // R1: detect, configure, initialise
        ST_DETECT: begin
          init_done <= 1'b0;
          if (present_s) begin
            state_r <= ST_CONFIG;
          end
        end
        ST_CONFIG: begin
          cfg_sel_r <= id_s;
          cnt_r     <= 10'h000;
          state_r   <= ST_INIT;
        end
        ST_INIT: begin
          cnt_r <= cnt_r + 10'h001;
          if (cnt_r == INIT_CYC - 10'h001) begin
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // R3: init complete output
          init_done <= 1'b1;
          // R15: row and block from control word
          if (cw_take) begin
            cw_last_r <= cw_data;
            loaded_r  <= 1'b0;
            arr_block <= cw_data[`MBL_CW_BLK_HI:`MBL_CW_BLK_LO];
            arr_row   <= (cw_data[`MBL_CW_ROW_HI:`MBL_CW_ROW_LO] < `MBL_BLOCK_ROWS) ?
                         cw_data[`MBL_CW_ROW_HI:`MBL_CW_ROW_LO] : 8'h00;
            state_r   <= ST_OPEN;
          end
        end
        ST_OPEN: begin
          // R8: end of block request
          if (req_rise) begin
            cnt_r   <= 10'h000;
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // A block is only complete once every queued word has reached the array.
          if (cnt_r != LOAD_CYC) begin
            cnt_r <= cnt_r + 10'h001;
          end else if (!fifo_out_valid) begin
            loaded_r <= 1'b1;
            blocks_r <= blocks_r + 8'h01;
            state_r  <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_DETECT;
        end
      endcase
      if (reinit_r || !present_s) begin
        state_r   <= ST_DETECT;
        loaded_r  <= 1'b0;
        init_done <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate_r           <= PS_IDLE;
      pcnt_r             <= 10'h000;
      go_q_r             <= 1'b0;
      mirror_clock_pulse <= 1'b0;
      pulse_type_out     <= 2'h0;
      pulse_block_out    <= 4'h0;
      pulses_r           <= 8'h00;
    end else begin
      go_q_r             <= go_s;
      mirror_clock_pulse <= 1'b0;
      case (pstate_r)
        PS_IDLE: begin
          // R16: starts while busy are dropped
          if (go_take) begin
            // R14: latch pulse kind
            pulse_type_out     <= type_s;
            pulse_block_out    <= blk_s;
            mirror_clock_pulse <= 1'b1;
            pcnt_r             <= 10'h000;
            pulses_r           <= pulses_r + 8'h01;
            pstate_r           <= PS_RUN;
          end
        end
        PS_RUN: begin
          pcnt_r <= pcnt_r + 10'h001;
          if (pcnt_r == PULSE_CYC - 10'h001) begin
            pcnt_r   <= 10'h000;
            pstate_r <= PS_SETTLE;
          end
        end
        PS_SETTLE: begin
          // Mirrors need to settle before another pulse can be trusted.
          pcnt_r <= pcnt_r + 10'h001;
          if (pcnt_r == SETTLE_CYC - 10'h001) begin
            pstate_r <= PS_IDLE;
          end
        end
        default: begin
          pstate_r <= PS_IDLE;
        end
      endcase

      // A restart abandons any pulse, so no pulse outlives the array setup.
      if (reinit_r || !present_s) begin
        pstate_r           <= PS_IDLE;
        pcnt_r             <= 10'h000;
        mirror_clock_pulse <= 1'b0;
      end
    end
  end

  // Zero wait states: every access completes in its first access cycle.
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite & hit;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~hit;

  // R4: status and identity readback
  always @* begin
    rd_val = 32'h00000000;
    hit    = 1'b1;
    case (paddr)
      `MBL_OFS_CTRL:   rd_val = {31'h00000000, fwd_en_r};
      `MBL_OFS_STATUS: rd_val = {17'h00000, state_r, 2'h0, cfg_sel_r, 2'h0, present_s,
                                 loaded_r, mirror_pulse_running, ~block_busy_n,
                                 init_done, config_done};
      `MBL_OFS_INFO:   rd_val = {VERSION, DEV_ID};
      `MBL_OFS_CWLO:   rd_val = cw_last_r[31:0];
      `MBL_OFS_CWHI:   rd_val = cw_last_r[63:32];
      `MBL_OFS_COUNT:  rd_val = {3'h0, fifo_level, drops_r, pulses_r, blocks_r};
      default:         hit    = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata   <= 32'h00000000;
      fwd_en_r <= `MBL_CTRL_RESET;
      reinit_r <= 1'b0;
    end else begin
      reinit_r <= 1'b0;
      // Read data is taken in setup so it stands through the access cycle.
      if (apb_setup) begin
        prdata <= rd_val;
      end
      if (apb_wr && (paddr == `MBL_OFS_CTRL)) begin
        fwd_en_r <= pwdata[`MBL_CTRL_FWD];
        reinit_r <= pwdata[`MBL_CTRL_REINIT];
      end
    end
  end
endmodule

// ===== mbl_defines.vh
// Constants shared by the mirror block load sequencer files.
// Behaviour
// R1: Detect array, pick config, initialise before use.
// R2: Host waits for configuration-complete output.
// R3: Raise init-complete after setup; host waits.
// R4: Status, version and ID readable on request.
// R5: Host sends control word on channel 0 first.
// R6: Control words on channels 1-3 are discarded.
// R7: Host streams data only after control word.
// R8: Load request ends block, runs encoded operation.
// R9: Busy output low while operation executes.
// R10: Host waits for busy release before next word.
// R11: Host presents block select and pulse type.
// R12: Pulse start only after busy drops, block loaded.
// R13: Pulse-running output held during whole pulse.
// R14: Pulse type input selects applied pulse kind.
// R15: Forward data with row and block control.
// R16: Ignore load or pulse requests while busy.
`ifndef MBL_DEFINES_VH
`define MBL_DEFINES_VH

`define MBL_CLK_NS        10
`define MBL_PULSE_NS      4000
`define MBL_PULSE_CYC     (`MBL_PULSE_NS / `MBL_CLK_NS)
`define MBL_SETTLE_NS     4000
`define MBL_SETTLE_CYC    (`MBL_SETTLE_NS / `MBL_CLK_NS)
`define MBL_LOAD_PS       5044440
`define MBL_LOAD_CYC      ((`MBL_LOAD_PS + `MBL_CLK_NS * 1000 - 1) / (`MBL_CLK_NS * 1000))
`define MBL_INIT_CYC      64
`define MBL_BLOCK_ROWS    8'h88

`define MBL_OFS_CTRL      8'h00
`define MBL_OFS_STATUS    8'h04
`define MBL_OFS_INFO      8'h08
`define MBL_OFS_CWLO      8'h0c
`define MBL_OFS_CWHI      8'h10
`define MBL_OFS_COUNT     8'h14

`define MBL_CTRL_FWD      0
`define MBL_CTRL_REINIT   1
`define MBL_CTRL_RESET    1'b1

`define MBL_CW_ROW_HI     7
`define MBL_CW_ROW_LO     0
`define MBL_CW_BLK_HI     11
`define MBL_CW_BLK_LO     8

`define MBL_FIFO_W        32
`define MBL_FIFO_D        16
`define MBL_FIFO_AW       4

`endif

// ===== mbl_sync.v
// Two-flop synchroniser for a bundle of slow pin levels.
`timescale 1ns/1ns
module mbl_sync #(
  parameter W = 1
) (
  input  wire         pclk,    // system clock
  input  wire         presetn, // async reset, active low
  input  wire [W-1:0] d,       // asynchronous levels
  output wire [W-1:0] q        // synchronised levels
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;
endmodule

// ===== mbl_fifo.v
// Small flop-based FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module mbl_fifo #(
  parameter W  = 32,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          pclk,      // system clock
  input  wire          presetn,   // async reset, active low
  input  wire          in_valid,  // write request
  output wire          in_ready,  // not full
  input  wire [W-1:0]  in_data,   // write data
  output wire          out_valid, // not empty
  input  wire          out_ready, // read accept
  output wire [W-1:0]  out_data,  // head word
  output wire [AW:0]   level      // words held
);
  reg [W-1:0]  mem_r [0:D-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0]   cnt_r;
  wire         do_wr;
  wire         do_rd;

  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;
  assign out_data  = mem_r[rd_ptr_r];
  assign level     = cnt_r;

  always @(posedge pclk) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r    <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ===== mbl_checker_assertions.sv
// Concurrent checks on the load and pulse handshakes of mbl_top.
`timescale 1ns/1ns
`include "mbl_defines.vh"
module mbl_checker (
  input wire       pclk,                 // clock
  input wire       presetn,              // reset, low
  input wire       psel,                 // select
  input wire       penable,              // enable
  input wire       pready,               // ready
  input wire       pslverr,              // error
  input wire       init_done,            // init complete
  input wire       s_ready,              // stream ready
  input wire       block_load_request,   // end of block
  input wire       block_busy_n,         // busy, low
  input wire       mirror_pulse_running, // pulse on
  input wire       mirror_clock_pulse,   // pulse strobe
  input wire [1:0] pulse_type_out,       // pulse kind
  input wire [3:0] pulse_block_out       // pulse block
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [10:0] run_cnt_r;
  reg [10:0] busy_cnt_r;
  // Lengths of the running and busy phases, cleared between phases.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt_r  <= 11'h000;
      busy_cnt_r <= 11'h000;
    end else begin
      run_cnt_r  <= mirror_pulse_running ? run_cnt_r + 11'h001 : 11'h000;
      busy_cnt_r <= block_busy_n ? 11'h000 : busy_cnt_r + 11'h001;
    end
  end
  AST_PULSE_LEN: assert property ($fell(mirror_pulse_running) |->
    run_cnt_r == `MBL_PULSE_CYC) else $error("pulse length wrong");
  AST_BUSY_MIN: assert property ($rose(block_busy_n) |->
    busy_cnt_r >= `MBL_LOAD_CYC) else $error("busy too short");
  AST_STROBE_ONE: assert property (mirror_clock_pulse |=>
    !mirror_clock_pulse && mirror_pulse_running) else $error("strobe not single");
  AST_STROBE_START: assert property (mirror_clock_pulse |->
    $rose(mirror_pulse_running)) else $error("strobe without pulse start");
  AST_KIND_HOLD: assert property (mirror_pulse_running && !mirror_clock_pulse |->
    $stable(pulse_type_out) && $stable(pulse_block_out)) else $error("pulse kind moved");
  AST_GO_WHEN_FREE: assert property (mirror_clock_pulse |->
    $past(block_busy_n) && init_done) else $error("pulse while busy");
  AST_SETTLE: assert property ($fell(mirror_pulse_running) |->
    ##1 (!mirror_clock_pulse) [*8]) else $error("pulse during settle");
  AST_NO_INTAKE: assert property (s_ready |->
    block_busy_n && init_done) else $error("stream taken while busy");
  AST_INIT_FIRST: assert property (!init_done |->
    block_busy_n && !mirror_pulse_running) else $error("activity before init");
  AST_BUSY_CAUSE: assert property ($fell(block_busy_n) |->
    block_load_request) else $error("busy without request");
  AST_ERR_PHASE: assert property (pslverr |->
    psel && penable) else $error("error outside access");
  AST_NO_WAIT: assert property (psel && penable |->
    pready) else $error("wait state seen");
  cover property ($rose(mirror_pulse_running));
  cover property ($rose(block_busy_n));
  cover property (pslverr);
endmodule
bind mbl_top mbl_checker mbl_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .init_done(init_done), .s_ready(s_ready),
  .block_load_request(block_load_request), .block_busy_n(block_busy_n),
  .mirror_pulse_running(mirror_pulse_running), .mirror_clock_pulse(mirror_clock_pulse),
  .pulse_type_out(pulse_type_out), .pulse_block_out(pulse_block_out));

// ===== mbl_host.sv
// Host-side model feeding control words, stream data and block pins.
`timescale 1ns/1ns
module mbl_host (
  input  wire        pclk,                 // clock
  input  wire        config_done,          // config complete
  input  wire        init_done,            // init complete
  input  wire        block_busy_n,         // busy, low
  input  wire        s_ready,              // stream ready
  input  wire        mirror_pulse_running, // pulse on
  output reg         cw_valid,             // word valid
  output reg  [1:0]  cw_chan,              // word channel
  output reg  [63:0] cw_data,              // control word
  output reg         s_valid,              // stream valid
  output reg  [31:0] s_data,               // stream data
  output reg         block_load_request,   // end of block
  output reg  [3:0]  mirror_block_select,  // pulse block
  output reg  [1:0]  pulse_type_select,    // pulse kind
  output reg         mirror_pulse_go       // pulse start
);
  initial begin
    cw_valid = 1'b0;
    cw_chan = 2'h0;
    cw_data = 64'h0;
    s_valid = 1'b0;
    s_data = 32'h0;
    block_load_request = 1'b0;
    mirror_block_select = 4'h0;
    pulse_type_select = 2'h0;
    mirror_pulse_go = 1'b0;
  end
  task send_cw(input [1:0] ch, input [63:0] w);
    begin
      while (!config_done || !init_done || !block_busy_n)
        @(posedge pclk);
      cw_valid <= 1'b1;
      cw_chan <= ch;
      cw_data <= w;
      @(posedge pclk);
      cw_valid <= 1'b0;
      cw_data <= ~w;
      @(posedge pclk);
    end
  endtask
  task stream(input [31:0] base, input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        s_valid <= 1'b1;
        s_data <= base + j;
        @(posedge pclk);
        while (!s_ready)
          @(posedge pclk);
      end
      s_valid <= 1'b0;
      s_data <= ~s_data;
    end
  endtask
  task load;
    begin
      block_load_request <= 1'b1;
      @(posedge pclk);
      while (block_busy_n)
        @(posedge pclk);
      block_load_request <= 1'b0;
    end
  endtask
  task pulse(input [3:0] b, input [1:0] t, output ok);
    integer j;
    begin
      mirror_block_select <= b;
      pulse_type_select <= t;
      repeat (4) @(posedge pclk);
      mirror_pulse_go <= 1'b1;
      ok = 1'b0;
      for (j = 0; j < 8; j = j + 1) begin
        @(posedge pclk);
        ok = ok | mirror_pulse_running;
      end
      mirror_pulse_go <= 1'b0;
    end
  endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the mirror block load sequencer.
`timescale 1ns/1ns
module testbench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0, rd, rnd, base, q[$];
  reg  [1:0]  array_id = 2'h0, t;
  reg         array_present = 1'b1, arr_ready = 1'b0, stall = 1'b1;
  reg         err, ok, seen_init = 1'b0;
  reg  [7:0]  erow;
  reg  [63:0] cw;
  reg  [3:0]  eblk, b;
  integer     n_errors = 0, tests_run = 0, seed = 19, cyc = 0, k, i;
  wire [31:0] prdata, arr_data, s_data;
  wire [63:0] cw_data;
  wire [7:0]  arr_row;
  wire [3:0]  arr_block, pulse_block_out, mirror_block_select;
  wire [1:0]  cw_chan, pulse_type_out, pulse_type_select;
  wire        pready, pslverr, config_done, init_done, cw_valid, s_valid, s_ready;
  wire        block_load_request, block_busy_n, mirror_pulse_go, mirror_pulse_running;
  wire        arr_valid, arr_init, mirror_clock_pulse;
  mbl_top mbl_top_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .array_present(array_present), .array_id(array_id), .config_done(config_done),
    .init_done(init_done), .cw_valid(cw_valid), .cw_chan(cw_chan), .cw_data(cw_data),
    .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
    .block_load_request(block_load_request), .block_busy_n(block_busy_n),
    .mirror_block_select(mirror_block_select), .pulse_type_select(pulse_type_select),
    .mirror_pulse_go(mirror_pulse_go), .mirror_pulse_running(mirror_pulse_running),
    .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_data(arr_data), .arr_row(arr_row),
    .arr_block(arr_block), .arr_init(arr_init), .mirror_clock_pulse(mirror_clock_pulse),
    .pulse_type_out(pulse_type_out), .pulse_block_out(pulse_block_out));
  mbl_host mbl_host_i (
    .pclk(pclk), .config_done(config_done), .init_done(init_done),
    .block_busy_n(block_busy_n), .s_ready(s_ready),
    .mirror_pulse_running(mirror_pulse_running), .cw_valid(cw_valid), .cw_chan(cw_chan),
    .cw_data(cw_data), .s_valid(s_valid), .s_data(s_data),
    .block_load_request(block_load_request), .mirror_block_select(mirror_block_select),
    .pulse_type_select(pulse_type_select), .mirror_pulse_go(mirror_pulse_go));
  always #5 pclk = ~pclk;
  function [7:0] next_row(input [7:0] r);
    next_row = (r == 8'h87) ? 8'h00 : r + 8'h01;
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("BAD at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task close_out;
    begin
      $display("Counts: %0d checks, %0d mismatches", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] wd);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (!pready)
        @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // The array side accepts at random once the fill test is over.
  always @(posedge pclk) begin
    rnd = $random(seed);
    arr_ready <= !stall && rnd[0];
    cyc <= cyc + 1;
    if (arr_init)
      seen_init <= 1'b1;
    if (arr_valid && arr_ready) begin
      chk(arr_data, q.pop_front());
      chk({arr_block, arr_row}, {eblk, erow});
      erow = next_row(erow);
    end
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end
  initial begin
    rnd = $random(seed);
    array_id <= rnd[1:0];
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, config_done}, 32'h1);
    for (k = 0; k < 300 && !init_done; k = k + 1)
      @(posedge pclk);
    chk({seen_init, init_done}, 32'h3);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h01005a01);
    apb(1'b0, 8'h04, 32'h0);
    chk({rd[14:12], rd[9:8], rd[5:0]}, {3'h3, array_id, 6'h23});
    apb(1'b1, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    $display("test init done");
    for (i = 1; i < 4; i = i + 1)
      mbl_host_i.send_cw(i[1:0], 64'h0);
    repeat (3) @(posedge pclk);
    apb(1'b0, 8'h14, 32'h0);
    chk({s_ready, rd[23:16]}, 32'h3);
    $display("test side channels done");
    for (k = 0; k < 3; k = k + 1) begin
      rnd = $random(seed);
      {t, b, eblk, erow} = {rnd[17:12], rnd[11:8], 1'b0, rnd[6:0]};
      // Corner rows: the last row wraps, an out-of-range row restarts at 0.
      if (k > 0)
        erow = (k == 1) ? 8'h87 : 8'h00;
      base = $random(seed);
      cw = {base, 20'h0, eblk, (k == 2) ? 8'hc8 : erow};
      for (i = 0; i < 20; i = i + 1)
        q.push_back(base + i);
      mbl_host_i.send_cw(2'h0, cw);
      fork
        mbl_host_i.stream(base, 20);
        begin
          repeat (40) @(posedge pclk);
          apb(1'b0, 8'h14, 32'h0);
          if (k == 0)
            chk({s_ready, rd[28:24]}, 32'h10);
          stall <= 1'b0;
        end
      join
      fork
        mbl_host_i.load;
        begin
          repeat (12) @(posedge pclk);
          mbl_host_i.pulse(b, t, ok);
          chk({31'h0, ok}, 32'h0);
        end
      join
      for (i = 0; i < 3000 && !block_busy_n; i = i + 1)
        @(posedge pclk);
      apb(1'b0, 8'h04, 32'h0);
      chk({rd[4], rd[2]}, 2'h2);
      chk(q.size(), 0);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, cw[31:0]);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, cw[63:32]);
      apb(1'b0, 8'h14, 32'h0);
      chk({rd[28:24], rd[7:0]}, k + 1);
      mbl_host_i.pulse(b, t, ok);
      chk({ok, mirror_pulse_running, pulse_block_out, pulse_type_out}, {2'h3, b, t});
      repeat (800) @(posedge pclk);
      $display("test block %0d done", k);
    end
    close_out;
  end
endmodule
